// ===== design/data_format_defs.svh
// Purpose: constants for the data format lane steering block
// Assumes: 32-bit register path, byte-wide memory lanes in a 32-bit word
// Notes: definitions only
`ifndef DATA_FORMAT_DEFS_SVH
`define DATA_FORMAT_DEFS_SVH

// ****************************************
// widths and field positions
// ****************************************
`define WORD_W 32
`define HALF_W 16
`define BYTE_W 8
`define Q24_LSB 8
`define Q24_W 24
`define BIT_IDX_W 5
`define ACC_W 64
`define ACC_GUARD_W 72
// largest positive fraction in a register
`define FRAC_MAX 32'h7fffffff
`define FRAC_MIN 32'h80000000

`endif

// ===== design/data_format_pkg.sv
// Purpose: types for the data format lane steering block
// Assumes: data_format_defs.svh holds the numbers
// Notes: types only
package data_format_pkg;
   // access size of a load or store
   typedef enum logic [1:0] {
      size_byte,
      size_half,
      size_word
   } size_type;
   // widening operation applied to a loaded value
   typedef enum logic [2:0] {
      ext_none,
      zero_extend_byte,
      sign_extend_byte,
      zero_extend_half,
      sign_extend_half
   } ext_type;
   // bit operation on a register
   typedef enum logic [1:0] {
      bit_test,
      bit_set,
      bit_clear,
      bit_invert
   } bitop_type;
   // extended arithmetic operand layout
   typedef enum logic [1:0] {
      xa_upper16,
      xa_lower16,
      xa_dual16,
      xa_frac24
   } xa_type;
endpackage

// ===== design/data_format_lane_steering.sv
// Purpose: lane steering, extension, bit select and fraction formatting
// Assumes: one registered answer per cycle, one cycle after the request
// Notes: big-endian is a build parameter only; little-endian by default
`include "data_format_defs.svh"

module data_format_lane_steering
   import data_format_pkg::*;
#(
   parameter bit big_endian = 1'b0,
   parameter bit trap_misaligned = 1'b1
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // memory access request from the core
   input wire logic acc_valid,
   input wire logic acc_store,
   input wire size_type acc_size,
   input wire ext_type acc_ext,
   input wire logic [1:0] acc_addr,
   input wire logic [`WORD_W-1:0] reg_wdata,
   input wire logic [`WORD_W-1:0] mem_rdata,
   // memory side answer
   output logic [`WORD_W-1:0] mem_wdata,
   output logic [3:0] mem_be,
   output logic mem_valid,
   output logic misaligned,
   // register side load result
   output logic [`WORD_W-1:0] load_data,
   output logic load_valid,
   // bit operations
   input wire logic bit_valid,
   input wire bitop_type bit_op,
   input wire logic [`BIT_IDX_W-1:0] bit_idx,
   input wire logic [`WORD_W-1:0] bit_src,
   output logic [`WORD_W-1:0] bit_result,
   output logic bit_flag,
   // extended arithmetic operands and fraction products
   input wire logic xa_valid,
   input wire xa_type xa_fmt,
   input wire logic frac_shift,
   input wire logic [`WORD_W-1:0] xa_a,
   input wire logic [`WORD_W-1:0] xa_b,
   output logic [`WORD_W-1:0] xa_op_a,
   output logic [`WORD_W-1:0] xa_op_b,
   output logic [`WORD_W-1:0] frac_hi,
   output logic [`WORD_W-1:0] frac_hi2,
   output logic [`ACC_GUARD_W-1:0] frac_acc,
   output logic frac_sat,
   output logic xa_done
);

   // ****************************************
   // memory lane steering
   // ****************************************
   logic [`WORD_W-1:0] next_wdata;
   logic [3:0] next_be;
   logic next_mis;
   logic [`BYTE_W-1:0] rbyte;
   logic [`HALF_W-1:0] rhalf;
   logic [`WORD_W-1:0] rword;
   logic [`WORD_W-1:0] next_load;

   // lanes: lane k holds address N+k inside the aligned word
   always_comb begin
      next_wdata = '0;
      next_be = 4'h0;
      next_mis = 1'b0;
      case (acc_size)
         size_byte: begin
            // byte lands at its own address whatever the order
            next_wdata = {4{reg_wdata[`BYTE_W-1:0]}};
            next_be = 4'h1 << acc_addr;
         end
         size_half: begin
            next_mis = acc_addr[0];
            if (big_endian) begin
               // high byte first
               next_wdata = {2{reg_wdata[`BYTE_W-1:0], reg_wdata[`HALF_W-1:`BYTE_W]}};
            end else begin
               // low byte first
               next_wdata = {2{reg_wdata[`HALF_W-1:0]}};
            end
            next_be = acc_addr[1] ? 4'hc : 4'h3;
         end
         size_word: begin
            next_mis = acc_addr != 2'h0;
            if (big_endian) begin
               next_wdata = {reg_wdata[7:0], reg_wdata[15:8],
                             reg_wdata[23:16], reg_wdata[31:24]};
            end else begin
               next_wdata = reg_wdata;
            end
            next_be = 4'hf;
         end
         default: begin
            next_be = 4'h0;
         end
      endcase
   end

   // picking load lanes back out of the memory word
   always_comb begin
      rbyte = mem_rdata[`BYTE_W*acc_addr +: `BYTE_W];
      if (big_endian) begin
         rhalf = acc_addr[1] ? {mem_rdata[23:16], mem_rdata[31:24]}
                             : {mem_rdata[7:0], mem_rdata[15:8]};
         rword = {mem_rdata[7:0], mem_rdata[15:8], mem_rdata[23:16], mem_rdata[31:24]};
      end else begin
         rhalf = acc_addr[1] ? mem_rdata[31:16] : mem_rdata[15:0];
         rword = mem_rdata;
      end
   end

   // widen into the low bits of the register
   always_comb begin
      case (acc_size)
         size_byte: next_load = {{(`WORD_W-`BYTE_W){1'b0}}, rbyte};
         size_half: next_load = {{(`WORD_W-`HALF_W){1'b0}}, rhalf};
         default: next_load = rword;
      endcase
      case (acc_ext)
         zero_extend_byte: next_load = {{(`WORD_W-`BYTE_W){1'b0}}, next_load[`BYTE_W-1:0]};
         sign_extend_byte: next_load = {{(`WORD_W-`BYTE_W){next_load[`BYTE_W-1]}},
                                        next_load[`BYTE_W-1:0]};
         zero_extend_half: next_load = {{(`WORD_W-`HALF_W){1'b0}}, next_load[`HALF_W-1:0]};
         sign_extend_half: next_load = {{(`WORD_W-`HALF_W){next_load[`HALF_W-1]}},
                                        next_load[`HALF_W-1:0]};
         default: next_load = next_load;
      endcase
   end

   // store side outputs; a trapped access drives no byte enables
   always_ff @(posedge mclk) begin
      if (rst) begin
         mem_wdata <= '0;
         mem_be <= 4'h0;
         mem_valid <= 1'b0;
         misaligned <= 1'b0;
      end else begin
         mem_wdata <= next_wdata;
         mem_valid <= acc_valid && acc_store && !(trap_misaligned && next_mis);
         mem_be <= (acc_valid && acc_store && !(trap_misaligned && next_mis)) ? next_be : 4'h0;
         misaligned <= acc_valid && trap_misaligned && next_mis;
      end
   end

   // load side outputs
   always_ff @(posedge mclk) begin
      if (rst) begin
         load_data <= '0;
         load_valid <= 1'b0;
      end else begin
         if (acc_valid && !acc_store) begin
            load_data <= next_load;
         end
         load_valid <= acc_valid && !acc_store && !(trap_misaligned && next_mis);
      end
   end

   // ****************************************
   // single bit operations
   // ****************************************
   logic [`WORD_W-1:0] bit_mask;
   assign bit_mask = `WORD_W'(1) << bit_idx;

   always_ff @(posedge mclk) begin
      if (rst) begin
         bit_result <= '0;
         bit_flag <= 1'b0;
      end else if (bit_valid) begin
         bit_flag <= |(bit_src & bit_mask);
         case (bit_op)
            bit_set: bit_result <= bit_src | bit_mask;
            bit_clear: bit_result <= bit_src & ~bit_mask;
            bit_invert: bit_result <= bit_src ^ bit_mask;
            default: bit_result <= bit_src;
         endcase
      end
   end

   // ****************************************
   // extended arithmetic operands
   // ****************************************
   logic [`WORD_W-1:0] next_opa;
   logic [`WORD_W-1:0] next_opb;
   logic signed [`ACC_W-1:0] prod;
   logic signed [`ACC_W-1:0] next_prod;
   logic [`WORD_W-1:0] mul_a;
   logic [`WORD_W-1:0] mul_b;

   // single-channel operands come out left justified as signed fractions
   function automatic logic [`WORD_W-1:0] pick(input xa_type f, input logic [`WORD_W-1:0] v);
      case (f)
         xa_upper16: pick = {v[`WORD_W-1:`HALF_W], {`HALF_W{1'b0}}};
         xa_lower16: pick = {v[`HALF_W-1:0], {`HALF_W{1'b0}}};
         xa_frac24: pick = {v[`WORD_W-1:`Q24_LSB], {`Q24_LSB{1'b0}}};
         default: pick = v; // dual keeps both channels in place
      endcase
   endfunction

   always_comb begin
      next_opa = pick(xa_fmt, xa_a);
      next_opb = pick(xa_fmt, xa_b);
      // dual format multiplies channel 1 only here; channel 2 goes on frac_hi2
      mul_a = (xa_fmt == xa_dual16) ? pick(xa_upper16, xa_a) : next_opa;
      mul_b = (xa_fmt == xa_dual16) ? pick(xa_upper16, xa_b) : next_opb;
      prod = $signed(mul_a) * $signed(mul_b);
      // unshifted keeps the doubled sign; shifted drops it, zero in lsb
      next_prod = frac_shift ? (prod <<< 1) : prod;
   end

   // channel 2 product for dual 16-bit work
   logic signed [`WORD_W-1:0] prod2;
   assign prod2 = $signed(xa_a[`HALF_W-1:0]) * $signed(xa_b[`HALF_W-1:0]);

   // ****************************************
   // fraction result registers
   // ****************************************
   // -1 times -1 shifted overflows 64 bits; guard accumulator keeps it exact
   always_ff @(posedge mclk) begin
      if (rst) begin
         xa_op_a <= '0;
         xa_op_b <= '0;
         frac_hi <= '0;
         frac_hi2 <= '0;
         frac_acc <= '0;
         frac_sat <= 1'b0;
         xa_done <= 1'b0;
      end else begin
         xa_done <= xa_valid;
         if (xa_valid) begin
            xa_op_a <= next_opa;
            xa_op_b <= next_opb;
            // the shift moves every bit up one place, so the true sign is prod's top bit
            frac_acc <= {{(`ACC_GUARD_W-`ACC_W){prod[`ACC_W-1]}},
                         next_prod};
            if (frac_shift && mul_a == `FRAC_MIN && mul_b == `FRAC_MIN) begin
               frac_hi <= `FRAC_MAX;
               frac_sat <= 1'b1;
            end else begin
               frac_hi <= next_prod[`ACC_W-1:`WORD_W];
               frac_sat <= 1'b0;
            end
            frac_hi2 <= frac_shift ? (prod2 <<< 1) : prod2;
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   byte_lane_a: assert property (@(posedge mclk) disable iff (rst)
      acc_valid && acc_store && acc_size == size_byte |=>
      mem_be == $past(4'h1 << acc_addr))
      else $error("byte lane wrong");
   word_order_a: assert property (@(posedge mclk) disable iff (rst)
      !big_endian && acc_valid && acc_store && acc_size == size_word |=>
      mem_wdata == $past(reg_wdata))
      else $error("little word order wrong");
   half_low_a: assert property (@(posedge mclk) disable iff (rst)
      !big_endian && acc_valid && acc_store && acc_size == size_half |=>
      mem_wdata[7:0] == $past(reg_wdata[7:0]))
      else $error("half low byte wrong");
   sext_byte_a: assert property (@(posedge mclk) disable iff (rst)
      acc_valid && !acc_store && acc_ext == sign_extend_byte |=>
      load_data[31:8] == {24{load_data[7]}})
      else $error("byte sign extension wrong");
   zext_half_a: assert property (@(posedge mclk) disable iff (rst)
      acc_valid && !acc_store && acc_ext == zero_extend_half |=> load_data[31:16] == 16'h0)
      else $error("half zero extension wrong");
   misalign_trap_a: assert property (@(posedge mclk) disable iff (rst)
      trap_misaligned && acc_valid && acc_size == size_word && acc_addr != 2'h0 |=>
      misaligned && mem_be == 4'h0 && !load_valid)
      else $error("misaligned word not trapped");
   bit_pick_a: assert property (@(posedge mclk) disable iff (rst)
      bit_valid |=> bit_flag == $past(bit_src[bit_idx]))
      else $error("bit select wrong");
   frac24_a: assert property (@(posedge mclk) disable iff (rst)
      xa_valid && xa_fmt == xa_frac24 |=> xa_op_a[7:0] == 8'h0)
      else $error("24-bit low byte not ignored");
   qshift_lsb_a: assert property (@(posedge mclk) disable iff (rst)
      xa_valid && frac_shift |=> frac_acc[0] == 1'b0 ##1 1'b1)
      else $error("shifted lsb not zero");
   noq_sign_a: assert property (@(posedge mclk) disable iff (rst)
      xa_valid && !frac_shift && !(mul_a == `FRAC_MIN && mul_b == `FRAC_MIN) |=>
      frac_hi[31] == frac_hi[30])
      else $error("unshifted sign not doubled");
   minus_one_a: assert property (@(posedge mclk) disable iff (rst)
      xa_valid && !frac_shift && mul_a == `FRAC_MIN && mul_b == `FRAC_MIN |=>
      frac_hi == 32'h40000000 && !frac_sat)
      else $error("unshifted minus one squared wrong");

   store_cov: cover property (@(posedge mclk) acc_valid && acc_store ##1 mem_valid);
   load_cov: cover property (@(posedge mclk) acc_valid && !acc_store ##1 load_valid);
   sat_cov: cover property (@(posedge mclk) xa_valid ##1 frac_sat);
   trap_cov: cover property (@(posedge mclk) misaligned);

endmodule

// ===== tb/data_mem_model.sv
// Purpose: byte-lane data memory word facing the lane steering block
// Assumes: one aligned word, lane k holds byte address N+k
// Notes: behavioural, read answers in the same cycle
`include "data_format_defs.svh"
module data_mem_model (
   // clock
   input wire logic mclk,
   // write lanes from the block
   input wire logic mem_valid,
   input wire logic [3:0] mem_be,
   input wire logic [`WORD_W-1:0] mem_wdata,
   // read word to the block
   output logic [`WORD_W-1:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [`WORD_W-1:0] word = 32'h0;
   // read path has no wait state, the block gives none
   assign mem_rdata = word;
   // only enabled lanes change, so a byte write leaves its neighbours alone
   always @(posedge mclk) begin
      for (int k = 0; k < 4; k++) begin
         if (mem_valid && mem_be[k]) begin
            word[8*k +: 8] <= mem_wdata[8*k +: 8];
         end
      end
   end
endmodule

// ===== tb/testbench.sv
// Purpose: self-checking bench for the lane steering block
// Assumes: both byte orders built side by side, memory written by the default one
// Notes: loads follow stores after one idle cycle so the memory write lands first
`include "data_format_defs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import data_format_pkg::*;
   typedef struct {logic st; size_type sz; ext_type ex; logic [1:0] ad;
      logic [31:0] d; logic [3:0] en; logic [31:0] le, bx;} acc_row_type;
   typedef struct {xa_type f; logic sh; logic [31:0] a, b;} xa_row_type;
   logic mclk = 0, rst = 1, acc_valid = 0, acc_store = 0, bit_valid = 0, xa_valid = 0;
   logic frac_shift = 0;
   size_type acc_size = size_word;
   ext_type acc_ext = ext_none;
   bitop_type bit_op = bit_test;
   xa_type xa_fmt = xa_upper16;
   logic [1:0] acc_addr = 2'h0;
   logic [4:0] bit_idx = 5'h0;
   logic [31:0] reg_wdata = 32'h0, bit_src = 32'h0, xa_a = 32'h0, xa_b = 32'h0;
   logic [31:0] mem_rdata, mem_wdata, load_data, bit_result, xa_op_a, xa_op_b;
   logic [31:0] frac_hi, frac_hi2, be_wdata, be_load;
   logic [3:0] mem_be;
   logic mem_valid, misaligned, load_valid, bit_flag, frac_sat, xa_done;
   logic [71:0] frac_acc;
   int n_fail = 0, samples_checked = 0;
   // halfword rows stay on even addresses
   acc_row_type rows [11] = '{
      '{1, size_word, ext_none, 2'h0, 32'ha1b2c3f4, 4'hf, 32'ha1b2c3f4, 32'hf4c3b2a1},
      '{0, size_word, ext_none, 2'h0, 32'h0, 4'h0, 32'ha1b2c3f4, 32'hf4c3b2a1},
      '{0, size_byte, sign_extend_byte, 2'h1, 32'h0, 4'h0, 32'hffffffc3, 32'hffffffc3},
      '{0, size_byte, zero_extend_byte, 2'h3, 32'h0, 4'h0, 32'h000000a1, 32'h000000a1},
      '{0, size_byte, ext_none, 2'h0, 32'h0, 4'h0, 32'h000000f4, 32'h000000f4},
      '{0, size_half, sign_extend_half, 2'h2, 32'h0, 4'h0, 32'hffffa1b2, 32'hffffb2a1},
      '{0, size_half, zero_extend_half, 2'h0, 32'h0, 4'h0, 32'h0000c3f4, 32'h0000f4c3},
      '{1, size_half, ext_none, 2'h2, 32'hdead5566, 4'hc, 32'h55660000, 32'h66550000},
      '{1, size_byte, ext_none, 2'h1, 32'h12345677, 4'h2, 32'h00007700, 32'h00007700},
      '{0, size_word, ext_none, 2'h0, 32'h0, 4'h0, 32'h556677f4, 32'hf4776655},
      '{0, size_half, ext_none, 2'h2, 32'h0, 4'h0, 32'h00005566, 32'h00006655}};
   xa_row_type xrows [7] = '{
      '{xa_upper16, 0, 32'h40001234, 32'h4000ffff}, '{xa_upper16, 1, 32'h40001234, 32'h4000ffff},
      '{xa_lower16, 1, 32'hffffc000, 32'h12344000}, '{xa_frac24, 0, 32'h800000ab, 32'h80000012},
      '{xa_frac24, 1, 32'h800000ab, 32'h80000012}, '{xa_dual16, 0, 32'h4000c000, 32'h40004000},
      '{xa_dual16, 1, 32'hc0007fff, 32'h40007fff}};

   // ****************************************
   // design, partner and clock
   // ****************************************
   data_format_lane_steering dut (
      .mclk(mclk), .rst(rst), .acc_valid(acc_valid), .acc_store(acc_store),
      .acc_size(acc_size), .acc_ext(acc_ext), .acc_addr(acc_addr), .reg_wdata(reg_wdata),
      .mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_valid(mem_valid),
      .misaligned(misaligned), .load_data(load_data), .load_valid(load_valid),
      .bit_valid(bit_valid), .bit_op(bit_op), .bit_idx(bit_idx), .bit_src(bit_src),
      .bit_result(bit_result), .bit_flag(bit_flag), .xa_valid(xa_valid), .xa_fmt(xa_fmt),
      .frac_shift(frac_shift), .xa_a(xa_a), .xa_b(xa_b), .xa_op_a(xa_op_a), .xa_op_b(xa_op_b),
      .frac_hi(frac_hi), .frac_hi2(frac_hi2), .frac_acc(frac_acc), .frac_sat(frac_sat),
      .xa_done(xa_done));
   // big-endian build shares the stimulus, only its lane data is judged
   data_format_lane_steering #(.big_endian(1'b1)) dut_be (
      .mclk(mclk), .rst(rst), .acc_valid(acc_valid), .acc_store(acc_store),
      .acc_size(acc_size), .acc_ext(acc_ext), .acc_addr(acc_addr), .reg_wdata(reg_wdata),
      .mem_rdata(mem_rdata), .mem_wdata(be_wdata), .mem_be(), .mem_valid(), .misaligned(),
      .load_data(be_load), .load_valid(), .bit_valid(bit_valid), .bit_op(bit_op),
      .bit_idx(bit_idx), .bit_src(bit_src), .bit_result(), .bit_flag(), .xa_valid(xa_valid),
      .xa_fmt(xa_fmt), .frac_shift(frac_shift), .xa_a(xa_a), .xa_b(xa_b), .xa_op_a(),
      .xa_op_b(), .frac_hi(), .frac_hi2(), .frac_acc(), .frac_sat(), .xa_done());
   data_mem_model mem (.mclk(mclk), .mem_valid(mem_valid), .mem_be(mem_be),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   initial forever #50 mclk = ~mclk;

   // ****************************************
   // checks and references
   // ****************************************
   task automatic chk_word(logic [71:0] got, logic [71:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(logic got, logic exp);
      chk_word({71'h0, got}, {71'h0, exp});
   endtask
   task automatic chk_zero;
      chk_word({mem_wdata, load_data}, 72'h0);
      chk_word({bit_result, frac_hi}, 72'h0);
      chk_word(frac_acc, 72'h0);
      chk_word({mem_be, mem_valid, misaligned, load_valid, bit_flag, frac_sat, xa_done}, 72'h0);
   endtask
   task automatic test_done;
      $display("checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // caller lowers the valid, so back-to-back calls assign it once per step
   task automatic acc_req(logic st, size_type sz, ext_type ex, logic [1:0] ad, logic [31:0] d);
      acc_store = st;
      acc_size = sz;
      acc_ext = ex;
      acc_addr = ad;
      reg_wdata = d;
      acc_valid = 1;
      @(posedge mclk);
      #1;
   endtask
   function automatic logic [31:0] just(xa_type f, logic [31:0] v);
      case (f)
         xa_upper16: return {v[31:16], 16'h0};
         xa_lower16: return {v[15:0], 16'h0};
         xa_frac24: return {v[31:8], 8'h0};
         default: return v;
      endcase
   endfunction
   function automatic logic [71:0] prod(logic [31:0] x, logic [31:0] y, logic sh);
      logic signed [71:0] p;
      p = $signed(x) * $signed(y);
      return sh ? p <<< 1 : p;
   endfunction
   initial begin
      repeat (5000) @(posedge mclk);
      n_fail++;
      test_done();
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      logic [31:0] m, e;
      logic [63:0] ops;
      logic [71:0] pa, pb;
      logic sat;
      xa_type f1;
      repeat (16) @(posedge mclk);
      #1 rst = 0;
      @(posedge mclk);
      #1;
      chk_zero();
      foreach (rows[i]) begin
         acc_req(rows[i].st, rows[i].sz, rows[i].ex, rows[i].ad, rows[i].d);
         m = {{8{rows[i].en[3]}}, {8{rows[i].en[2]}}, {8{rows[i].en[1]}}, {8{rows[i].en[0]}}};
         chk_word(rows[i].st ? mem_wdata & m : load_data, rows[i].le);
         chk_word(rows[i].st ? be_wdata & m : be_load, rows[i].bx);
         chk_word(mem_be, rows[i].en);
         chk_bit(rows[i].st ? mem_valid : load_valid, 1'b1);
         chk_bit(misaligned, 1'b0);
         acc_valid = 0;
         @(posedge mclk);
         #1;
         chk_bit(mem_valid | load_valid, 1'b0);
      end
      // trapped accesses back to back, then prove the store wrote nothing
      acc_req(1, size_half, ext_none, 2'h1, 32'hffffffff);
      chk_word({misaligned, mem_be, mem_valid}, 72'h20);
      for (int a = 1; a < 4; a++) begin
         acc_req(0, size_word, ext_none, a[1:0], 32'h0);
         chk_word({misaligned, load_valid}, 72'h2);
      end
      acc_req(0, size_word, ext_none, 2'h0, 32'h0);
      chk_word(load_data, 72'h556677f4);
      acc_valid = 0;
      for (int i = 0; i < 32; i++) begin
         for (int k = 0; k < 4; k++) begin
            bit_op = bitop_type'(k[1:0]);
            bit_idx = i[4:0];
            bit_src = 32'h3c5a96e1;
            bit_valid = 1;
            @(posedge mclk);
            #1;
            m = 32'h1 << i;
            e = k == 1 ? bit_src | m : k == 2 ? bit_src & ~m : bit_src ^ m;
            if (k == 0) chk_bit(bit_flag, bit_src[i]);
            else chk_word(bit_result, e);
         end
      end
      bit_valid = 0;
      foreach (xrows[i]) begin
         xa_fmt = xrows[i].f;
         frac_shift = xrows[i].sh;
         xa_a = xrows[i].a;
         xa_b = xrows[i].b;
         xa_valid = 1;
         @(posedge mclk);
         #1;
         f1 = xa_fmt == xa_dual16 ? xa_upper16 : xa_fmt;
         pa = prod(just(f1, xa_a), just(f1, xa_b), frac_shift);
         pb = prod(just(xa_lower16, xa_a), just(xa_lower16, xa_b), frac_shift);
         sat = frac_shift && just(f1, xa_a) == `FRAC_MIN && just(f1, xa_b) == `FRAC_MIN;
         chk_bit(xa_done, 1'b1);
         chk_word(frac_hi, sat ? `FRAC_MAX : pa[63:32]);
         chk_bit(frac_sat, sat);
         ops = {just(xa_fmt, xa_a), just(xa_fmt, xa_b)};
         if (xa_fmt == xa_dual16) chk_word(frac_hi2, pb[63:32]);
         else chk_word(frac_acc, pa);
         chk_word({xa_op_a, xa_op_b}, ops);
      end
      xa_valid = 0;
      @(posedge mclk);
      #1;
      chk_bit(xa_done, 1'b0);
      rst = 1;
      @(posedge mclk);
      #1;
      chk_zero();
      rst = 0;
      test_done();
   end
endmodule
